// ---- bench/tb_top.sv ----
// Self-checking bench for tcv_chan with the timer model.
// Assumes a 10 MHz clock and APB completion within twenty cycles.
`default_nettype none

`define CHK(g, e) \
   begin \
      checked++; \
      if ((g) !== (e)) begin \
         n_errors++; \
         $display("Error t=%0t got %h exp %h", $time, (g), (e)); \
      end \
   end

module tb_top
   import tcv_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, cps = 1'h0, run = 1'h0, pin_lvl = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, pin_out, pin_oe, chan_irq, irq, rerr;
   logic [15:0] cnt_val;
   logic cnt_tick, cnt_up, pin_in;
   int n_errors = 0, checked = 0;

   always #50 clk_sys = ~clk_sys;

   tcv_chan tcv_chan_inst (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .center_pwm_select(cps), .cnt_val(cnt_val), .cnt_tick(cnt_tick),
      .cnt_up(cnt_up), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .chan_irq(chan_irq), .irq(irq));
   tcv_partner tcv_partner_inst (.clk_sys(clk_sys), .nrst(nrst), .run(run),
      .center(cps), .pin_lvl(pin_lvl), .cnt_val(cnt_val),
      .cnt_tick(cnt_tick), .cnt_up(cnt_up), .pin_in(pin_in));

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      k = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'h1;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'h1 && k < 20);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // Idle edge, so the next call never re-raises psel in this step
      @(posedge clk_sys);
      if (k >= 20) begin
         n_errors++;
         stop_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'h1, a, d);
   endtask

   task automatic rd8(input logic [7:0] a);
      apb(1'h0, a, 8'h00);
   endtask

   // Returns at the edge where the counter shows v in direction u
   task automatic wait_cnt(input logic [15:0] v, input logic u);
      int k;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (!(cnt_tick === 1'h1 && cnt_val === v && cnt_up === u)
         && k < 200);
      if (k >= 200) begin
         n_errors++;
         stop_test();
      end
   endtask

   task automatic t_regs();
      logic [7:0] offs[4];
      offs = '{TCV_OFF_CTRL, TCV_OFF_VALH, TCV_OFF_VALL, TCV_OFF_IMSK};
      foreach (offs[i]) begin
         rd8(offs[i]);
         `CHK(rd, 32'h0)
      end
      rd8(8'h14);
      `CHK(rerr, 1'h1)
   endtask

   task automatic t_compare();
      logic p;
      wr(TCV_OFF_CTRL, 8'h14);
      wr(TCV_OFF_VALL, 8'h05);
      wr(TCV_OFF_CTRL, 8'h14);
      wr(TCV_OFF_VALH, 8'h00);
      rd8(TCV_OFF_VALL);
      `CHK(rd[7:0], 8'h00)
      wr(TCV_OFF_VALL, 8'h05);
      rd8(TCV_OFF_VALL);
      `CHK(rd[7:0], 8'h05)
      wr(TCV_OFF_IMSK, 8'h02);
      run <= 1'h1;
      for (int e = 0; e < 4; e++) begin
         wr(TCV_OFF_CTRL, 8'h50 | 8'(e << 2));
         wait_cnt(16'h9, 1'h1);
         p = pin_out;
         wait_cnt(16'h5, 1'h1);
         @(posedge clk_sys);
         `CHK(pin_oe, e != 0)
         if (e == 1) `CHK(pin_out, !p)
         if (e > 1) `CHK(pin_out, e[0])
         @(posedge clk_sys);
         `CHK({chan_irq, irq}, 2'h3)
      end
      run <= 1'h0;
      rd8(TCV_OFF_ISTS);
      `CHK(rd[1:0], 2'h2)
      rd8(TCV_OFF_ISTS);
      `CHK({irq, rd[1:0]}, 3'h0)
      wr(TCV_OFF_CTRL, 8'h5c);
      rd8(TCV_OFF_CTRL);
      `CHK(rd[7], 1'h1)
      wr(TCV_OFF_CTRL, 8'hdc);
      rd8(TCV_OFF_CTRL);
      `CHK(rd[7], 1'h1)
      wr(TCV_OFF_CTRL, 8'h5c);
      rd8(TCV_OFF_CTRL);
      `CHK({rd[7], chan_irq}, 2'h0)
   endtask

   task automatic t_epwm();
      logic [7:0] cfg[2];
      cfg = '{8'h38, 8'h24};
      run <= 1'h1;
      foreach (cfg[i]) begin
         wr(TCV_OFF_CTRL, cfg[i]);
         wait_cnt(16'h9, 1'h1);
         wait_cnt(16'h3, 1'h1);
         `CHK(pin_out, !cfg[i][2])
         wait_cnt(16'h8, 1'h1);
         `CHK(pin_out, cfg[i][2])
      end
      wait_cnt(16'h1, 1'h1);
      wr(TCV_OFF_VALH, 8'h00);
      wr(TCV_OFF_VALL, 8'h09);
      rd8(TCV_OFF_VALL);
      `CHK(rd[7:0], 8'h05)
      wait_cnt(16'h2, 1'h1);
      rd8(TCV_OFF_VALL);
      `CHK(rd[7:0], 8'h09)
      wr(TCV_OFF_VALL, 8'h05);
      wr(TCV_OFF_VALH, 8'h00);
   endtask

   task automatic t_cpwm();
      cps <= 1'h1;
      wr(TCV_OFF_CTRL, 8'h08);
      // Start from the bottom turn so an up-match follows the new setup
      wait_cnt(16'h0, 1'h0);
      wait_cnt(16'h8, 1'h1);
      `CHK({pin_oe, pin_out}, 2'h2)
      wait_cnt(16'h2, 1'h0);
      `CHK(pin_out, 1'h1)
      cps <= 1'h0;
      run <= 1'h0;
   endtask

   task automatic t_capture();
      logic [7:0] c1;
      logic [7:0] c2;
      for (int e = 1; e < 4; e++) begin
         wr(TCV_OFF_CTRL, 8'(e << 2));
         for (int s = 0; s < 2; s++) begin
            rd8(TCV_OFF_CTRL);
            wr(TCV_OFF_CTRL, 8'(e << 2));
            pin_lvl <= !pin_lvl;
            repeat (6) @(posedge clk_sys);
            rd8(TCV_OFF_CTRL);
            `CHK(rd[7], e[s])
         end
      end
      @(posedge clk_sys);
      c1 = cnt_val[7:0];
      pin_lvl <= !pin_lvl;
      repeat (6) @(posedge clk_sys);
      rd8(TCV_OFF_VALL);
      `CHK(rd[7:0], c1)
      run <= 1'h1;
      repeat (3) @(posedge clk_sys);
      run <= 1'h0;
      @(posedge clk_sys);
      c2 = cnt_val[7:0];
      pin_lvl <= !pin_lvl;
      repeat (6) @(posedge clk_sys);
      rd8(TCV_OFF_VALL);
      `CHK(rd[7:0], c1)
      wr(TCV_OFF_CTRL, 8'h0c);
      rd8(TCV_OFF_VALL);
      `CHK(rd[7:0], c2)
   endtask

   // Reset for six cycles, then each scenario in turn
   initial begin
      repeat (6) @(posedge clk_sys);
      nrst <= 1'h1;
      @(posedge clk_sys);
      t_regs();
      t_compare();
      t_epwm();
      t_cpwm();
      t_capture();
      stop_test();
   end
endmodule

`default_nettype wire

// ---- bench/tcv_monitor.sv ----
// Port checker for the timer channel, bound to tcv_chan.
// Assumes one clock; shadows control and mask writes seen on the bus.
`default_nettype none

module tcv_monitor
   import tcv_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [TCV_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic center_pwm_select,
   input wire logic pin_oe,
   input wire logic chan_irq,
   input wire logic irq
);
   logic [7:0] ctl_r;
   logic [1:0] msk_r;
   logic [1:0] age_r;
   logic cps_r;
   logic wr;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   assign wr = psel && penable && pready && pwrite;
   // Age counts settled cycles, so registered outputs may lag a change
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ctl_r <= 8'h00;
         msk_r <= 2'h0;
         age_r <= 2'h0;
         cps_r <= 1'h0;
      end else begin
         cps_r <= center_pwm_select;
         if (wr && paddr == TCV_OFF_CTRL) begin
            ctl_r <= pwdata[7:0];
         end
         if (wr && paddr == TCV_OFF_IMSK) begin
            msk_r <= pwdata[1:0];
         end
         if ((wr && paddr == TCV_OFF_CTRL) ||
             center_pwm_select != cps_r) begin
            age_r <= 2'h0;
         end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
         end
      end
   end

   pready_slot_a: assert property (psel && penable && !pready |=> pready)
      else $error("No ready in second access cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("Slave error without ready");
   reset_quiet_a: assert property (!$past(nrst) |->
      !pready && !pin_oe && !irq && !chan_irq)
      else $error("Outputs active right after reset");
   pin_release_a: assert property (age_r[1] && ctl_r[3:2] == 2'h0
      |-> !pin_oe) else $error("Pin driven with edge/level 00");
   capture_input_a: assert property (age_r[1] && !cps_r
      && ctl_r[5:4] == 2'h0 |-> !pin_oe) else $error("Capture drives pin");
   output_drive_a: assert property (age_r[1] && ctl_r[3:2] != 2'h0
      && (cps_r || ctl_r[5] || ctl_r[4]) |-> pin_oe)
      else $error("Output mode leaves pin undriven");
   chan_gate_a: assert property (age_r[1] && !ctl_r[6] |-> !chan_irq)
      else $error("Channel interrupt while disabled");
   mask_gate_a: assert property (msk_r == 2'h0 && $past(msk_r) == 2'h0
      |-> !irq) else $error("Interrupt with all sources masked");
endmodule

bind tcv_chan tcv_monitor tcv_monitor_inst (.clk_sys(clk_sys), .nrst(nrst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .center_pwm_select(center_pwm_select), .pin_oe(pin_oe),
   .chan_irq(chan_irq), .irq(irq));

`default_nettype wire

// ---- bench/tcv_partner.sv ----
// Model of the timer core and pin source around the channel.
// Counts each clock while run is high and holds otherwise.
`default_nettype none

module tcv_partner #(parameter logic [15:0] MOD = 16'h000f) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic run,
   input wire logic center,
   input wire logic pin_lvl,
   output logic [15:0] cnt_val,
   output logic cnt_tick,
   output logic cnt_up,
   output logic pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic up_nxt;
   // Pin held stable by the bench around every mode change
   assign pin_in = pin_lvl;
   // Center select turns the counter into an up/down counter
   always_comb up_nxt = !center ||
      (cnt_up ? cnt_val != MOD : cnt_val == 16'h0);
   // Tick marks a cycle in which cnt_val holds a fresh count
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cnt_val <= 16'h0000;
         cnt_tick <= 1'h0;
         cnt_up <= 1'h1;
      end else begin
         cnt_tick <= run;
         if (run) begin
            cnt_up <= up_nxt;
            cnt_val <= !up_nxt ? cnt_val - 16'h1 :
               (cnt_val == MOD ? 16'h0 : cnt_val + 16'h1);
         end
      end
   end
endmodule

`default_nettype wire

// ---- design/tcv_chan.sv ----
// One capture/compare/PWM channel with its APB register file.
// Assumes the main counter, its tick and direction, and the center-PWM
// select come from timer logic on the same clock; the pin is async.
//
// Implementation choices: the APB slave port and the address map.
`default_nettype none

// Operation
// - Center select 0 and high mode bit 1 gives edge-aligned PWM.
// - Otherwise low mode bit picks input capture or output compare.
// - Edge/level bits 00 release the pin from the channel entirely.
// - Capture edges: 01 rising, 10 falling, 11 both.
// - Compare pin action: 00 none, 01 toggle, 10 clear, 11 set.
// - Edge PWM: 10 high-true cleared on match, X1 low-true set.
// - Center select 1 forces center-aligned PWM, counter counts up/down.
// - Center PWM: 10 cleared on up-match, X1 set on up-match.
// - Without center select each channel is configured on its own.
// - Value register holds capture or compare value, zero after reset.
// - Capture mode: reading one byte freezes both until other is read.
// - Writing status/control releases the capture read freeze.
// - Compare/PWM: byte writes buffered, moved once both bytes written.
// - Writing status/control restarts the value write buffer.
// - Flag clears by read-while-set then write 0; new event disarms the clear.
// - Channel interrupt while flag and enable are set; both reset.
// - Edge PWM moves buffered value only when the counter is zero.
module tcv_chan
   import tcv_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [TCV_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic center_pwm_select,
   input wire logic [15:0] cnt_val,
   input wire logic cnt_tick,
   input wire logic cnt_up,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic chan_irq,
   output logic irq
);

   tcv_chan_st_t r;
   tcv_chan_st_t n;

   logic pin_sync;
   logic pin_rise;
   logic pin_fall;
   tcv_mode_t mode;
   logic acc_first;
   logic acc_done;
   logic rd_first;
   logic wr_done;
   logic aligned;
   logic hit_ctrl;
   logic hit_valh;
   logic hit_vall;
   logic hit_ists;
   logic hit_imsk;
   logic mapped;
   logic released;
   logic cap_evt;
   logic match;
   logic period_start;
   logic cnt_zero;
   logic [15:0] rd_val;

   // Pin passes two flops before the edge detector looks at it
   tcv_sync u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   tcv_edge u_edge (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .lvl(pin_sync),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // APB phases: first access cycle computes read data, second completes
   assign acc_first = psel && penable && !r.pready;
   assign acc_done = psel && penable && r.pready;
   assign rd_first = acc_first && !pwrite;
   assign wr_done = acc_done && pwrite && mapped;

   // Address decode; unaligned or unknown addresses are errors
   assign aligned = paddr[1:0] == 2'b00;
   assign hit_ctrl = aligned && paddr == TCV_OFF_CTRL;
   assign hit_valh = aligned && paddr == TCV_OFF_VALH;
   assign hit_vall = aligned && paddr == TCV_OFF_VALL;
   assign hit_ists = aligned && paddr == TCV_OFF_ISTS;
   assign hit_imsk = aligned && paddr == TCV_OFF_IMSK;
   assign mapped = hit_ctrl || hit_valh || hit_vall || hit_ists || hit_imsk;

   // Mode decode; center select overrides the channel's own bits
   assign mode = center_pwm_select ? TCV_M_CPWM :
                 r.msh ? TCV_M_EPWM :
                 r.msl ? TCV_M_CMP : TCV_M_CAP;

   // Edge/level 00 takes the pin away from the channel
   assign released = !r.elh && !r.ell;

   // Active edge; with both select bits low no edge is ever active
   assign cap_evt = (mode == TCV_M_CAP) &&
                    ((r.ell && pin_rise) || (r.elh && pin_fall));

   // Match counts once per counter step, not once per bus clock
   assign match = (mode != TCV_M_CAP) && cnt_tick && (cnt_val == r.value);
   assign cnt_zero = cnt_val == TCV_CNT_ZERO;
   assign period_start = cnt_tick && cnt_zero;

   // Frozen buffer is shown only while a capture read is pending
   assign rd_val = (mode == TCV_M_CAP && r.rd_lat) ? r.rbuf : r.value;

   // Next-state logic for registers, value buffers, pin and interrupts
   always_comb begin
      n = r;

      // Bus answer: pready one cycle into the access phase
      n.pready = acc_first;
      n.pslverr = acc_first && !mapped;
      if (acc_first) begin
         n.prdata = 32'h0000_0000;
      end

      // Read data, sampled in the first access cycle
      if (rd_first) begin
         if (hit_ctrl) begin
            n.prdata[TCV_B_FLAG] = r.flag;
            n.prdata[TCV_B_IE] = r.ie;
            n.prdata[TCV_B_MSH] = r.msh;
            n.prdata[TCV_B_MSL] = r.msl;
            n.prdata[TCV_B_ELH] = r.elh;
            n.prdata[TCV_B_ELL] = r.ell;
         end
         if (hit_valh) begin
            n.prdata[7:0] = rd_val[15:8];
         end
         if (hit_vall) begin
            n.prdata[7:0] = rd_val[7:0];
         end
         if (hit_ists) begin
            n.prdata[TCV_NIRQ-1:0] = r.sts;
         end
         if (hit_imsk) begin
            n.prdata[TCV_NIRQ-1:0] = r.msk;
         end
      end

      // Reading the control word with the flag set arms the clear
      if (rd_first && hit_ctrl && r.flag) begin
         n.clr_arm = 1'b1;
      end

      // Capture read freeze: first byte latches both, other byte frees
      if (rd_first && (hit_valh || hit_vall) && mode == TCV_M_CAP) begin
         if (!r.rd_lat) begin
            n.rd_lat = 1'b1;
            n.rbuf = r.value;
            n.rd_hi_first = hit_valh;
         end else if (hit_valh != r.rd_hi_first) begin
            n.rd_lat = 1'b0;
         end
      end

      // Status clears on read; events below still win this cycle
      if (rd_first && hit_ists) begin
         n.sts = '0;
      end

      // Control write: configuration, flag clear, buffer restarts
      if (wr_done && hit_ctrl) begin
         n.ie = pwdata[TCV_B_IE];
         n.msh = pwdata[TCV_B_MSH];
         n.msl = pwdata[TCV_B_MSL];
         n.elh = pwdata[TCV_B_ELH];
         n.ell = pwdata[TCV_B_ELL];
         // Writing one to the flag does nothing
         if (!pwdata[TCV_B_FLAG] && r.clr_arm) begin
            n.flag = 1'b0;
         end
         n.clr_arm = 1'b0;
         n.rd_lat = 1'b0;
         n.got_hi = 1'b0;
         n.got_lo = 1'b0;
      end

      // Value byte writes; capture mode writes the value directly
      if (wr_done && hit_valh) begin
         if (mode == TCV_M_CAP) begin
            n.value[15:8] = pwdata[7:0];
         end else begin
            n.wbuf[15:8] = pwdata[7:0];
            n.got_hi = 1'b1;
         end
      end
      if (wr_done && hit_vall) begin
         if (mode == TCV_M_CAP) begin
            n.value[7:0] = pwdata[7:0];
         end else begin
            n.wbuf[7:0] = pwdata[7:0];
            n.got_lo = 1'b1;
         end
      end

      // Buffered value moves as one word; edge PWM waits for count zero
      // so a duty change never cuts a period short
      if (mode != TCV_M_CAP && n.got_hi && n.got_lo &&
          (mode != TCV_M_EPWM || cnt_zero)) begin
         n.value = n.wbuf;
         n.got_hi = 1'b0;
         n.got_lo = 1'b0;
      end

      // Capture takes the counter; it overrides a same-cycle write
      if (cap_evt) begin
         n.value = cnt_val;
      end

      // Flag sets on events; a new event also restarts the clear
      // sequence, so the set wins over a clear in the same cycle
      if (cap_evt || match) begin
         n.flag = 1'b1;
         n.clr_arm = 1'b0;
      end

      // Sticky interrupt status bits, one per event kind
      if (cap_evt) begin
         n.sts[TCV_I_CAP] = 1'b1;
      end
      if (match) begin
         n.sts[TCV_I_CMP] = 1'b1;
      end

      // Pin level per mode
      case (mode)
         TCV_M_CMP: begin
            if (match) begin
               case ({r.elh, r.ell})
                  2'b01: n.pin_lvl = !r.pin_lvl;
                  2'b10: n.pin_lvl = 1'b0;
                  2'b11: n.pin_lvl = 1'b1;
                  default: n.pin_lvl = r.pin_lvl;
               endcase
            end
         end
         TCV_M_EPWM: begin
            // Match after period start, so a zero value gives 0% duty
            if (period_start) begin
               n.pin_lvl = !r.ell;
            end
            if (match) begin
               n.pin_lvl = r.ell;
            end
         end
         TCV_M_CPWM: begin
            // Up-count match ends the pulse, down-count match starts it
            if (match) begin
               n.pin_lvl = cnt_up ? r.ell : !r.ell;
            end
         end
         default: begin
            n.pin_lvl = r.pin_lvl;
         end
      endcase

      // Drive the pin only for output modes that own it
      n.pin_oe = (mode != TCV_M_CAP) && !released;

      // Interrupt outputs follow the next state, so no extra lag
      n.ch_irq = n.flag && n.ie;
      n.irq = |(n.sts & n.msk);

      // Mask write last; it only gates, never sets status
      if (wr_done && hit_imsk) begin
         n.msk = pwdata[TCV_NIRQ-1:0];
         n.irq = |(n.sts & pwdata[TCV_NIRQ-1:0]);
      end
   end

   // All state in one register; reset clears every field
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         r <= TCV_ST_RST;
      end else begin
         r <= n;
      end
   end

   // Outputs straight from the state register
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign pin_out = r.pin_lvl;
   assign pin_oe = r.pin_oe;
   assign chan_irq = r.ch_irq;
   assign irq = r.irq;

endmodule

`default_nettype wire

// ---- design/tcv_edge.sv ----
// Rising and falling edge detector with registered one-cycle pulses.
// Assumes its input is already synchronous to clk_sys.
`default_nettype none

module tcv_edge
   import tcv_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic lvl,
   output logic rise,
   output logic fall
);

   typedef struct packed {
      logic prev;
      logic rise;
      logic fall;
   } tcv_edge_st_t;

   tcv_edge_st_t r;
   tcv_edge_st_t n;

   // A high pin at reset release shows as one rising edge
   always_comb begin
      n = r;
      n.prev = lvl;
      n.rise = lvl && !r.prev;
      n.fall = !lvl && r.prev;
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         r <= TCV_EDGE_RST;
      end else begin
         r <= n;
      end
   end

   assign rise = r.rise;
   assign fall = r.fall;

endmodule

`default_nettype wire

// ---- design/tcv_pkg.sv ----
// Shared constants, types and reset values of the timer channel block.
// Assumes one 10 MHz bus clock and a synchronous, active-low reset.
`default_nettype none

package tcv_pkg;

   // Register byte addresses on the APB port, one aligned word each
   localparam logic [7:0] TCV_OFF_CTRL = 8'h00;
   localparam logic [7:0] TCV_OFF_VALH = 8'h04;
   localparam logic [7:0] TCV_OFF_VALL = 8'h08;
   localparam logic [7:0] TCV_OFF_ISTS = 8'h0c;
   localparam logic [7:0] TCV_OFF_IMSK = 8'h10;
   localparam int TCV_AW = 8;

   // Bit positions in the channel status/control register
   localparam int TCV_B_FLAG = 7;
   localparam int TCV_B_IE = 6;
   localparam int TCV_B_MSH = 5;
   localparam int TCV_B_MSL = 4;
   localparam int TCV_B_ELH = 3;
   localparam int TCV_B_ELL = 2;

   // Sticky event bits in the interrupt status and mask registers
   localparam int TCV_I_CAP = 0;
   localparam int TCV_I_CMP = 1;
   localparam int TCV_NIRQ = 2;

   // Counter value that starts an edge-aligned period
   localparam logic [15:0] TCV_CNT_ZERO = 16'h0000;

   // Channel operating modes, one-hot
   typedef enum logic [3:0] {
      TCV_M_CAP  = 4'b0001,
      TCV_M_CMP  = 4'b0010,
      TCV_M_EPWM = 4'b0100,
      TCV_M_CPWM = 4'b1000
   } tcv_mode_t;

   // Complete state of the channel top
   typedef struct packed {
      logic ie;
      logic msh;
      logic msl;
      logic elh;
      logic ell;
      logic flag;
      logic clr_arm;
      logic [15:0] value;
      logic [15:0] rbuf;
      logic [15:0] wbuf;
      logic rd_lat;
      logic rd_hi_first;
      logic got_hi;
      logic got_lo;
      logic pin_lvl;
      logic pin_oe;
      logic [TCV_NIRQ-1:0] sts;
      logic [TCV_NIRQ-1:0] msk;
      logic irq;
      logic ch_irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tcv_chan_st_t;

   // Every field of the channel state clears on reset
   localparam tcv_chan_st_t TCV_ST_RST = '0;

   localparam logic [1:0] TCV_SYNC_RST = 2'h0;
   localparam logic [2:0] TCV_EDGE_RST = 3'h0;

endpackage

`default_nettype wire

// ---- design/tcv_sync.sv ----
// Two-stage synchroniser for the channel pin input.
// Assumes an asynchronous level; only the second stage is read.
`default_nettype none

module tcv_sync
   import tcv_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic async_in,
   output logic sync_out
);

   typedef struct packed {
      logic s1;
      logic s2;
   } tcv_sync_st_t;

   tcv_sync_st_t r;
   tcv_sync_st_t n;

   // First stage feeds only the second
   always_comb begin
      n = r;
      n.s1 = async_in;
      n.s2 = r.s1;
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         r <= TCV_SYNC_RST;
      end else begin
         r <= n;
      end
   end

   assign sync_out = r.s2;

endmodule

`default_nettype wire
